// ==== rtl/sbrg_map.vh ====
// sbrg_map.vh - register offsets, field positions, reset values and divide counts
// for the serial bit-rate generator; included by the generator top module.
`ifndef SBRG_MAP_VH
`define SBRG_MAP_VH

// register addresses on the plain register port
`define SBRG_ADDR_RCV_CTRL 2'h0
`define SBRG_ADDR_DIVISOR 2'h1
`define SBRG_ADDR_TX_CTRL 2'h2
`define SBRG_ADDR_TIMER 2'h3

// reset values
`define SBRG_RST_DIVISOR 8'h00
`define SBRG_RST_TX_CTRL 8'h02
`define SBRG_RST_RCV_CTRL 8'h00

// transmit control field positions
`define SBRG_TX_SYNC_BIT 4
`define SBRG_TX_UNIMPL_BIT 3
`define SBRG_TX_HSEL_BIT 2
`define SBRG_TX_IDLE_BIT 1
// writable mask: bit 3 unimplemented, bit 1 transmitter-idle status is read only
`define SBRG_TX_WMASK 8'hF5

// postscale counts after the prescale-by-4 stage
`define SBRG_POST_ASYNC_LO 5'h10
`define SBRG_POST_ASYNC_HI 5'h04
`define SBRG_POST_SYNC 5'h01
`define SBRG_PRESCALE 2'h3

`endif

// ==== rtl/sbrg_divider.v ====
// sbrg_divider.v - counts enable pulses and emits one pulse every 'last'+1 of them.
// assumes: single clock, synchronous active-high clear; a limit of zero passes every enable.
`timescale 1ns/1ps
`default_nettype none

module sbrg_divider #(
  parameter WIDTH = 8
) (
  input wire sys_clk,
  input wire clr,
  input wire en,
  input wire [WIDTH-1:0] last,
  output wire tick
);

  reg [WIDTH-1:0] cnt_q;

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  // counts up to 'last', then wraps; tick is combinational so the caller
  // chains stages without adding a cycle of delay per stage
  assign tick = en && (cnt_q >= last);

  always @(posedge sys_clk) begin
    if (clr) begin
      cnt_q <= {WIDTH{1'b0}};
    end else if (tick) begin
      cnt_q <= {WIDTH{1'b0}};
    end else if (en) begin
      cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule

`default_nettype wire

// ==== rtl/sbrg_top.v ====
// sbrg_top.v - bit-rate generator for the combined async/sync serial port.
// assumes: one 20 MHz clock, registers reached over a plain strobe port,
// transmitter and receiver sit outside and take the tick and the sync bit.
`timescale 1ns/1ps
`default_nettype none
`include "sbrg_map.vh"

module sbrg_top #(
  parameter DIV_WIDTH = 8
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire [1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg bit_tick,
  output reg sync_mode,
  output reg high_speed_select
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [DIV_WIDTH-1:0] baud_divisor_q;
  reg [7:0] tx_ctrl_q;
  reg [7:0] rcv_ctrl_q;
  reg div_wr_q;
  wire div_wr;
  wire pre_tick;
  wire timer_tick;
  wire post_tick;
  wire sync_sel;
  wire hsel;
  reg [4:0] post_last;

  assign div_wr = reg_wr && (reg_addr == `SBRG_ADDR_DIVISOR);
  assign sync_sel = tx_ctrl_q[`SBRG_TX_SYNC_BIT];
  assign hsel = tx_ctrl_q[`SBRG_TX_HSEL_BIT];

  // software writes; the unimplemented bit is masked off on write
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      baud_divisor_q <= `SBRG_RST_DIVISOR;
      tx_ctrl_q <= `SBRG_RST_TX_CTRL;
      rcv_ctrl_q <= `SBRG_RST_RCV_CTRL;
    end else if (reg_wr) begin
      case (reg_addr)
        `SBRG_ADDR_DIVISOR: begin
          baud_divisor_q <= reg_wdata[DIV_WIDTH-1:0];
        end
        `SBRG_ADDR_TX_CTRL: begin
          tx_ctrl_q <= (reg_wdata & `SBRG_TX_WMASK) | (tx_ctrl_q & ~`SBRG_TX_WMASK);
        end
        `SBRG_ADDR_RCV_CTRL: begin
          rcv_ctrl_q <= reg_wdata;
        end
        default: begin
          rcv_ctrl_q <= rcv_ctrl_q;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // divide chain
  // ------------------------------------------------------------
  // the whole chain restarts on a divisor write so the new rate shows at once
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      div_wr_q <= 1'b0;
    end else begin
      div_wr_q <= div_wr;
    end
  end

  // postscale choice: sync forces one, else high-speed picks 4 or 16
  always @* begin
    if (sync_sel) begin
      post_last = `SBRG_POST_SYNC - 5'h01;
    end else if (hsel) begin
      post_last = `SBRG_POST_ASYNC_HI - 5'h01;
    end else begin
      post_last = `SBRG_POST_ASYNC_LO - 5'h01;
    end
  end

  // fixed prescale of 4 system clocks
  sbrg_divider #(
    .WIDTH(2)
  ) u_pre (
    .sys_clk(sys_clk),
    .clr(sys_rst || div_wr),
    .en(1'b1),
    .last(`SBRG_PRESCALE),
    .tick(pre_tick)
  );

  // shared free-running 8-bit timer, full unsigned divisor gives 1..256
  sbrg_divider #(
    .WIDTH(DIV_WIDTH)
  ) u_timer (
    .sys_clk(sys_clk),
    .clr(sys_rst || div_wr),
    .en(pre_tick),
    .last(baud_divisor_q),
    .tick(timer_tick)
  );

  // postscaler by 16, 4 or 1
  sbrg_divider #(
    .WIDTH(5)
  ) u_post (
    .sys_clk(sys_clk),
    .clr(sys_rst || div_wr),
    .en(timer_tick),
    .last(post_last),
    .tick(post_tick)
  );

  // ------------------------------------------------------------
  // outputs and read port
  // ------------------------------------------------------------
  // registered outputs; the tick lags the chain by one cycle, rate unchanged
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      bit_tick <= 1'b0;
      sync_mode <= 1'b0;
      high_speed_select <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      bit_tick <= post_tick;
      sync_mode <= sync_sel;
      high_speed_select <= hsel;
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `SBRG_ADDR_RCV_CTRL: reg_rdata <= rcv_ctrl_q;
          `SBRG_ADDR_DIVISOR: reg_rdata <= baud_divisor_q;
          `SBRG_ADDR_TX_CTRL: reg_rdata <= tx_ctrl_q & ~(8'h01 << `SBRG_TX_UNIMPL_BIT);
          `SBRG_ADDR_TIMER: reg_rdata <= {1'b0, div_wr_q, 6'h00};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ==== dv/sbrg_monitor.sv ====
// sbrg_monitor.sv - port assertions for the bit-rate generator
// assumes: bound to sbrg_top, one clock, synchronous reset high
`timescale 1ns/1ps
`default_nettype none
module sbrg_monitor (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic bit_tick,
  input wire logic sync_mode,
  input wire logic high_speed_select
);
  // ----------
  // properties
  // ----------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // shortest period is 4 clocks, so a tick is followed by 3 quiet ones
  a_tick_spacing: assert property (bit_tick |=> !bit_tick [*3])
    else $error("tick period below 4");
  a_clear_quiet: assert property (reg_wr && reg_addr == 2'h1 |-> ##2 !bit_tick [*2])
    else $error("tick soon after divisor write");
  a_unimpl_zero: assert property (reg_rd && reg_addr == 2'h2 |=> !reg_rdata[3])
    else $error("unimplemented bit read as one");
  // mode outputs are a registered copy of the control register, two edges after the write
  a_sync_copy: assert property (reg_wr && reg_addr == 2'h2 |-> ##2 sync_mode == $past(reg_wdata[4], 2))
    else $error("sync select not taken");
  a_hsel_copy: assert property (reg_wr && reg_addr == 2'h2 |-> ##2 high_speed_select == $past(reg_wdata[2], 2))
    else $error("high speed select not taken");
  a_mode_held: assert property (!(reg_wr && reg_addr == 2'h2) ##1 !(reg_wr && reg_addr == 2'h2) |=> $stable({sync_mode, high_speed_select}))
    else $error("mode outputs changed without write");
  a_div_readback: assert property (reg_wr && reg_addr == 2'h1 ##1 reg_rd && reg_addr == 2'h1 |=> reg_rdata == $past(reg_wdata, 2))
    else $error("divisor readback differs");
  a_txctl_read: assert property (reg_rd && reg_addr == 2'h2 |=> reg_rdata[4] == sync_mode && reg_rdata[2] == high_speed_select)
    else $error("control read disagrees with mode outputs");
endmodule
bind sbrg_top sbrg_monitor mon (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .bit_tick(bit_tick), .sync_mode(sync_mode), .high_speed_select(high_speed_select));
`default_nettype wire

// ==== dv/sbrg_top_tb.sv ====
// sbrg_top_tb.sv - self-checking bench for the bit-rate generator
// assumes: 20 MHz clock, registers at 0..3, periods counted in clocks
`timescale 1ns/1ps
`default_nettype none
module sbrg_top_tb;
  logic sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
  logic [1:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, d;
  logic bit_tick, sync_mode, high_speed_select;
  int fail_count = 0, checks_done = 0, cyc = 0, c, n;
  sbrg_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bit_tick(bit_tick), .sync_mode(sync_mode), .high_speed_select(high_speed_select));
  initial forever #25 sys_clk = ~sys_clk;
  // ----------
  // tasks
  // ----------
  // expected tick period: prescale 4, divisor term, then mode postscale
  function int per(int m, int k);
    return 4 * (k + 1) * (m > 1 ? 1 : m ? 4 : 16);
  endfunction
  task chk(input string s, input [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  // the strobe stays up after the edge; the next call, always a read, drops it
  task wr(input [1:0] a, input [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1;
    reg_rd <= 0;
    @(posedge sys_clk);
  endtask
  // data stands only in the cycle after the strobe, so look mid-cycle
  task rd(input [1:0] a, input [7:0] e);
    reg_addr <= a;
    reg_rd <= 1;
    reg_wr <= 0;
    @(posedge sys_clk);
    reg_rd <= 0;
    @(negedge sys_clk);
    chk("rdata", e, reg_rdata);
    @(posedge sys_clk);
  endtask
  task tick(output int k);
    k = 0;
    do begin
      @(posedge sys_clk);
      #1 k++;
    end while (bit_tick !== 1'b1);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // a hang counts as a mismatch; the run needs well under 20000 clocks
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict;
    end
  end
  // ----------
  // tests
  // ----------
  initial begin
    void'($urandom(78));
    repeat (3) @(posedge sys_clk);
    sys_rst <= 0;
    @(posedge sys_clk);
    rd(0, 8'h00);
    rd(1, 8'h00);
    rd(2, 8'h02);
    $display("reset test done");
    for (n = 0; n < 5; n++) begin
      d = n ? $urandom : 8'hFF;
      wr(2, d);
      rd(2, d & 8'hF5 | 8'h02);
    end
    $display("control test done");
    for (int m = 0; m < 4; m++) begin
      n = m == 2 ? 0 : m == 3 ? 255 : $urandom % 8;
      wr(2, {3'h0, m[1], 1'b0, m[0], 2'h0});
      rd(2, {3'h0, m[1], 1'b0, m[0], 2'h2});
      chk("mode", {m[1], m[0]}, {sync_mode, high_speed_select});
      wr(1, n[7:0]);
      rd(1, n[7:0]);
      tick(c);
      tick(c);
      chk("period", per(m, n), c);
      $display("mode %0d test done", m);
    end
    wr(1, 8'hFF);
    rd(1, 8'hFF);
    repeat (9) @(posedge sys_clk);
    wr(1, 8'h00);
    rd(3, 8'h40);
    tick(c);
    chk("restart", 1, c < 8);
    $display("restart test done");
    give_verdict;
  end
endmodule
`default_nettype wire
